// [puic_filter.sv]
// package of shared constants and types, plus the per-pin input filter
// assumes: one 100 MHz clock, asynchronous active-low reset, inputs pulled high
package puic_pkg;
  // timing
  localparam int CLK_MHZ       = 100;
  localparam int PULSE_MIN_US  = 100000;                 // 0.1 s least pulse
  localparam int PULSE_MIN_CYC = PULSE_MIN_US * CLK_MHZ;  // cycles in 0.1 s
  localparam int FILT_CYC      = PULSE_MIN_CYC / 2;      // glitch window
  localparam int CNT_W         = 24;
  // channels
  localparam int N_CH    = 3;
  localparam int CH_DIR  = 0;
  localparam int CH_TRIG = 1;
  localparam int CH_FOOT = 2;
  // register offsets
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam logic [7:0] ADDR_EVT   = 8'h08;
  localparam logic [7:0] ADDR_CHAIN = 8'h0C;
  // field positions
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_TRIG_BIT  = 4;
  localparam int CTRL_RUN_SET   = 5;
  localparam int CTRL_RUN_CLR   = 6;
  localparam int STAT_RUN_BIT   = 0;
  localparam int STAT_INF_BIT   = 1;
  localparam int STAT_TRIG_BIT  = 2;
  localparam int STAT_REFUSED   = 3;
  localparam int STAT_PIN_LSB   = 8;
  localparam int CHAIN_MIX_BIT  = 8;
  // chain limits and reset values
  localparam logic [6:0] CHAIN_MAX_SAME  = 7'h63;        // 99 pumps
  localparam logic [6:0] CHAIN_MAX_MIXED = 7'h05;        // 5 pumps
  localparam logic [6:0] CHAIN_CNT_RST   = 7'h01;
  localparam logic       TRIG_RST        = 1'b0;
  localparam logic       INFUSE_RST      = 1'b1;

  typedef enum logic [1:0] {FS_TOGGLE, FS_RISE_START, FS_FALL_START} puic_mode_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } puic_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } puic_wb_rsp_t;

  typedef struct packed {
    logic lvl;
    logic rise;
    logic fall;
  } puic_edge_t;

  typedef struct packed {
    logic             s1;
    logic             s2;
    logic             s3;
    logic [CNT_W-1:0] cnt;
    puic_edge_t       ev;
  } puic_filt_t;
endpackage : puic_pkg

`timescale 1ns/1ps
module puic_filter #(
  parameter int FILT = puic_pkg::FILT_CYC
) (
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic             pin,
  output puic_pkg::puic_edge_t  ev
);
  import puic_pkg::*;

  puic_filt_t q, d;

  // refuse a window the counter cannot hold
  if (FILT < 1 || FILT >= (1 << CNT_W)) begin : g_bad_filt
    $error("puic_filter: FILT out of range");
  end

  // sync chain, then a level must hold FILT cycles before it counts
  always_comb begin
    d         = q;
    d.s1      = pin;
    d.s2      = q.s1;
    d.s3      = q.s2;
    d.ev.rise = 1'b0;
    d.ev.fall = 1'b0;
    if (q.s2 == q.s3 && q.s3 != q.ev.lvl) begin
      if (q.cnt >= CNT_W'(FILT - 1)) begin
        d.ev.lvl  = q.s3;
        d.ev.rise = q.s3;
        d.ev.fall = ~q.s3;
        d.cnt     = '0;
      end else begin
        d.cnt = q.cnt + CNT_W'(1);
      end
    end else begin
      d.cnt = '0;
    end
  end

  // undriven pin reads as high from reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, cnt: '0, ev: '{lvl: 1'b1, rise: 1'b0, fall: 1'b0}};
    end else begin
      q <= d;
    end
  end

  assign ev = q.ev;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  edge_single_a: assert property (q.ev.rise | q.ev.fall |=> !(q.ev.rise | q.ev.fall))
    else $error("filter edge pulse longer than one cycle");
  level_change_a: assert property ($changed(q.ev.lvl) |-> (q.ev.rise == q.ev.lvl) && (q.ev.fall == !q.ev.lvl))
    else $error("filtered level changed without matching pulse");
endmodule : puic_filter

// [puic_top.sv]
// user i/o control: direction, event trigger and footswitch inputs,
// trigger and run indicator outputs, wishbone register slave
// assumes: pins are asynchronous to sys_clk; wishbone master on sys_clk
//
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps

// Notes on behaviour
// - a rising direction input sets the pump to infuse.
// - a falling direction input sets the pump to refill.
// - a falling event trigger fires one method event, a rising one does nothing.
// - in toggle mode each falling footswitch edge flips run and stop.
// - in rising-start mode a rising footswitch edge starts and a falling one stops.
// - in falling-start mode a falling footswitch edge starts and a rising one stops.
// - the footswitch mode is a stored setting chosen from exactly those three modes.
// - the trigger output is low after reset and moves only by method or serial command.
// - the run indicator is low while running and high while stopped.
// - a chain of pumps of one firmware generation holds up to 99 pumps.
module puic_top #(
  parameter int FILT = puic_pkg::FILT_CYC
) (
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire logic                  dir_pin,
  input  wire logic                  trig_pin,
  input  wire logic                  foot_pin,
  input  wire puic_pkg::puic_wb_req_t wb_req,
  output puic_pkg::puic_wb_rsp_t     wb_rsp,
  output logic                       trig_out,
  output logic                       run_n_out,
  output logic                       infuse,
  output logic                       method_evt
);
  import puic_pkg::*;

  typedef struct packed {
    puic_mode_t   mode;
    logic         trig;
    logic         run;
    logic         run_n;
    logic         infuse;
    logic         evt;
    logic [15:0]  evt_cnt;
    logic [6:0]   chain_cnt;
    logic         mixed;
    logic         refused;
    puic_wb_rsp_t rsp;
  } puic_state_t;

  puic_state_t q, d;
  puic_edge_t  ev [N_CH];
  logic [N_CH-1:0] pins;
  logic [N_CH-1:0] lvls;

  assign pins = {foot_pin, trig_pin, dir_pin};

  // one filter per input pin
  genvar gi;
  generate
    for (gi = 0; gi < N_CH; gi++) begin : g_ch
      puic_filter #(.FILT(FILT)) u_filt (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .pin     (pins[gi]),
        .ev      (ev[gi])
      );
      assign lvls[gi] = ev[gi].lvl;
    end
  endgenerate

  // the filter counter cannot hold a window outside this range
  if (FILT < 1 || FILT >= (1 << CNT_W)) begin : g_bad_filt
    $error("puic_top: FILT out of range");
  end

  // bus decode
  logic        req;
  logic        wr;
  logic [6:0]  new_cnt;
  logic        new_mix;
  logic [6:0]  limit;
  logic [31:0] rd;
  logic        ctrl_wr;
  logic        chain_wr;

  always_comb begin
    req     = wb_req.cyc & wb_req.stb & ~q.rsp.ack;
    wr      = req & wb_req.we;
    // write strobes for the two writable registers
    ctrl_wr  = wr & (wb_req.adr == ADDR_CTRL) & wb_req.sel[0];
    chain_wr = wr & (wb_req.adr == ADDR_CHAIN) & (wb_req.sel[0] | wb_req.sel[1]);
    new_cnt = wb_req.sel[0] ? wb_req.dat[6:0] : q.chain_cnt;
    new_mix = wb_req.sel[1] ? wb_req.dat[CHAIN_MIX_BIT] : q.mixed;
    limit   = new_mix ? CHAIN_MAX_MIXED : CHAIN_MAX_SAME;
    rd      = 32'h0000_0000;
    case (wb_req.adr)
      ADDR_CTRL: begin
        rd[CTRL_MODE_LSB +: 2] = q.mode;
        rd[CTRL_TRIG_BIT]      = q.trig;
      end
      ADDR_STAT: begin
        rd[STAT_RUN_BIT]             = q.run;
        rd[STAT_INF_BIT]             = q.infuse;
        rd[STAT_TRIG_BIT]            = q.trig;
        rd[STAT_REFUSED]             = q.refused;
        rd[STAT_PIN_LSB +: N_CH]     = lvls;
      end
      ADDR_EVT: begin
        rd[15:0] = q.evt_cnt;
      end
      ADDR_CHAIN: begin
        rd[6:0]           = q.chain_cnt;
        rd[CHAIN_MIX_BIT] = q.mixed;
      end
      default: begin
        rd = 32'h0000_0000;
      end
    endcase
  end

  // next state
  always_comb begin
    d         = q;
    d.evt     = 1'b0;
    d.rsp.ack = req;
    d.rsp.dat = req ? rd : 32'h0000_0000;

    // direction follows the filtered edges
    if (ev[CH_DIR].rise) begin
      d.infuse = 1'b1;
    end else if (ev[CH_DIR].fall) begin
      d.infuse = 1'b0;
    end

    // method event on falling trigger only
    if (ev[CH_TRIG].fall) begin
      d.evt     = 1'b1;
      d.evt_cnt = q.evt_cnt + 16'h0001;
    end

    // footswitch run control by stored mode
    case (q.mode)
      FS_TOGGLE: begin
        if (ev[CH_FOOT].fall) begin
          d.run = ~q.run;
        end
      end
      FS_RISE_START: begin
        if (ev[CH_FOOT].rise) begin
          d.run = 1'b1;
        end else if (ev[CH_FOOT].fall) begin
          d.run = 1'b0;
        end
      end
      FS_FALL_START: begin
        if (ev[CH_FOOT].fall) begin
          d.run = 1'b1;
        end else if (ev[CH_FOOT].rise) begin
          d.run = 1'b0;
        end
      end
      default: begin
        d.run = q.run;
      end
    endcase

    // register writes; software run commands override the footswitch
    if (ctrl_wr) begin
      if (wb_req.dat[CTRL_MODE_LSB +: 2] != 2'b11) begin
        d.mode = puic_mode_t'(wb_req.dat[CTRL_MODE_LSB +: 2]);
      end
      d.trig = wb_req.dat[CTRL_TRIG_BIT];
      if (wb_req.dat[CTRL_RUN_SET]) begin
        d.run = 1'b1;
      end else if (wb_req.dat[CTRL_RUN_CLR]) begin
        d.run = 1'b0;
      end
    end

    // chain size write is refused beyond the limit
    if (chain_wr) begin
      if (new_cnt != 7'h00 && new_cnt <= limit) begin
        d.chain_cnt = new_cnt;
        d.mixed     = new_mix;
        d.refused   = 1'b0;
      end else begin
        d.refused = 1'b1;
      end
    end

    d.run_n = ~d.run;
  end

  // state register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '{mode: FS_TOGGLE, trig: TRIG_RST, run: 1'b0, run_n: 1'b1, infuse: INFUSE_RST,
             evt: 1'b0, evt_cnt: 16'h0000, chain_cnt: CHAIN_CNT_RST, mixed: 1'b0,
             refused: 1'b0, rsp: '{ack: 1'b0, dat: 32'h0000_0000}};
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign wb_rsp     = q.rsp;
  assign trig_out   = q.trig;
  assign run_n_out  = q.run_n;
  assign infuse     = q.infuse;
  assign method_evt = q.evt;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // bus handshake steps
  sequence bus_req_s;
    req;
  endsequence
  sequence ctrl_write_s;
    ctrl_wr;
  endsequence
  sequence chain_write_s;
    chain_wr;
  endsequence
  // direction input edges
  sequence dir_rise_s;
    ev[CH_DIR].rise;
  endsequence
  sequence dir_fall_s;
    ev[CH_DIR].fall;
  endsequence
  sequence dir_quiet_s;
    !ev[CH_DIR].rise && !ev[CH_DIR].fall;
  endsequence
  // footswitch quiet and no software run command
  sequence foot_quiet_s;
    !ev[CH_FOOT].rise && !ev[CH_FOOT].fall && !ctrl_wr;
  endsequence

  // direction state
  dir_infuse_a: assert property (dir_rise_s |=> infuse)
    else $error("rising direction did not select infuse");
  dir_refill_a: assert property (dir_fall_s |=> !infuse)
    else $error("falling direction did not select refill");
  dir_steady_a: assert property (dir_quiet_s |=> $stable(infuse))
    else $error("direction changed without an edge");

  // method events
  trig_event_a: assert property (method_evt == $past(ev[CH_TRIG].fall))
    else $error("method event not tied to falling trigger");
  trig_rise_a: assert property (ev[CH_TRIG].rise |=> !method_evt)
    else $error("rising trigger fired an event");
  evt_count_a: assert property (method_evt |-> q.evt_cnt == $past(q.evt_cnt) + 16'h0001)
    else $error("event count not advanced with event");

  // footswitch run control
  toggle_flip_a: assert property (q.mode == FS_TOGGLE && ev[CH_FOOT].fall && !ctrl_wr
                                  |=> q.run != $past(q.run))
    else $error("toggle mode did not flip run");
  rise_start_a: assert property (q.mode == FS_RISE_START && !wr |->
                                 (ev[CH_FOOT].rise |=> q.run) and (ev[CH_FOOT].fall |=> !q.run))
    else $error("rising-start mode wrong");
  fall_start_a: assert property (q.mode == FS_FALL_START && !wr |->
                                 (ev[CH_FOOT].fall |=> q.run) and (ev[CH_FOOT].rise |=> !q.run))
    else $error("falling-start mode wrong");
  mode_legal_a: assert property (q.mode != puic_mode_t'(2'b11))
    else $error("footswitch mode holds illegal value");
  run_steady_a: assert property (foot_quiet_s |=> $stable(q.run))
    else $error("run changed without footswitch edge or command");
  sw_run_a: assert property (ctrl_write_s ##0 wb_req.dat[CTRL_RUN_SET] |=> q.run)
    else $error("software run set not applied");

  // trigger output and run indicator
  trig_hold_a: assert property (!$past(ctrl_wr) |-> $stable(trig_out))
    else $error("trigger output moved without a command");
  trig_cmd_a: assert property (ctrl_write_s |=> trig_out == $past(wb_req.dat[CTRL_TRIG_BIT]))
    else $error("trigger output did not follow command");
  run_led_a: assert property (run_n_out == !q.run)
    else $error("run indicator disagrees with run state");

  // chain size register
  chain_limit_a: assert property (q.chain_cnt <= (q.mixed ? CHAIN_MAX_MIXED : CHAIN_MAX_SAME))
    else $error("chain size beyond limit");
  chain_refuse_a: assert property (chain_write_s ##0 (new_cnt == 7'h00 || new_cnt > limit)
                                   |=> q.refused && $stable(q.chain_cnt))
    else $error("bad chain size was not refused");
  chain_keep_a: assert property (!chain_wr |=> $stable(q.chain_cnt))
    else $error("chain size moved without a write");

  // bus response
  ack_once_a: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack held longer than one cycle");
  ack_follow_a: assert property (bus_req_s |=> wb_rsp.ack)
    else $error("request not acknowledged next cycle");
  ack_data_a: assert property (bus_req_s |=> wb_rsp.dat == $past(rd))
    else $error("read data not the decoded register");
  idle_data_a: assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h0000_0000)
    else $error("read data not zero outside ack");
endmodule : puic_top

// [puic_pin_model.sv]
// far-side model: ttl equipment or footswitch on the three user inputs
// assumes: the bench calls drive(); released lines sit at the pull-up level
`timescale 1ns/1ps
module puic_pin_model (
  input  wire logic sys_clk,
  output logic      dir_pin,
  output logic      trig_pin,
  output logic      foot_pin
);
  // undriven inputs rest high through the pull-ups
  initial begin
    dir_pin  = 1'b1;
    trig_pin = 1'b1;
    foot_pin = 1'b1;
  end

  // set one line after an edge, then hold it for the given cycles
  task automatic drive(input int ch, input logic lvl, input int hold);
    @(posedge sys_clk);
    case (ch)
      0:       dir_pin  <= lvl;
      1:       trig_pin <= lvl;
      default: foot_pin <= lvl;
    endcase
    repeat (hold) @(posedge sys_clk);
  endtask : drive
endmodule : puic_pin_model

// [test_pump_user_io_control.sv]
// self-checking bench for the user i/o block: pin rows, then bus cases
// assumes: puic_pkg compiled first; filter window shortened to F cycles
`timescale 1ns/1ps
module test_pump_user_io_control;
  import puic_pkg::*;
  localparam int F = 8;
  typedef struct {int mode; int ch; logic lvl; logic inf; logic run_n; int evt;} puic_row_t;
  logic         sys_clk, nrst, dir_pin, trig_pin, foot_pin;
  logic         trig_out, run_n_out, infuse, method_evt;
  puic_wb_req_t wb_req;
  puic_wb_rsp_t wb_rsp;
  int           bad_count, tests_run, evt_seen;
  logic [31:0]  rd;
  // mode, channel, new level, then expected infuse, run_n and event count
  puic_row_t    rows [14] = '{'{0,0,0,0,1,0}, '{0,0,1,1,1,0}, '{0,1,0,1,1,1}, '{0,1,1,1,1,1},
    '{0,2,0,1,0,1}, '{0,2,1,1,0,1}, '{0,2,0,1,1,1}, '{0,2,1,1,1,1}, '{1,2,0,1,1,1},
    '{1,2,1,1,0,1}, '{1,2,0,1,1,1}, '{2,2,1,1,1,1}, '{2,2,0,1,0,1}, '{2,2,1,1,1,1}};
  // chain write, expected readback, expected refused flag
  logic [31:0]  chain [5][3] = '{'{32'h63, 32'h63, 0}, '{32'h64, 32'h63, 1},
    '{32'h106, 32'h63, 1}, '{32'h105, 32'h105, 0}, '{32'h0, 32'h105, 1}};

  puic_top #(.FILT(F)) dut (
    .sys_clk(sys_clk), .nrst(nrst), .dir_pin(dir_pin), .trig_pin(trig_pin),
    .foot_pin(foot_pin), .wb_req(wb_req), .wb_rsp(wb_rsp), .trig_out(trig_out),
    .run_n_out(run_n_out), .infuse(infuse), .method_evt(method_evt));

  puic_pin_model pins (
    .sys_clk(sys_clk), .dir_pin(dir_pin), .trig_pin(trig_pin), .foot_pin(foot_pin));

  // clock source
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // count cycles with the event pulse high, so a long pulse shows
  always @(posedge sys_clk) begin
    if (method_evt === 1'b1) evt_seen <= evt_seen + 1;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one classic cycle; waits for ack, then releases
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge sys_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    // no own limit: the watchdog ends a hang
    do begin
      @(posedge sys_clk);
    end while (wb_rsp.ack !== 1'b1);
    r = wb_rsp.dat;
    wb_req <= '0;
  endtask : wb

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // watchdog well past the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    $display("watchdog expired");
    stop_test();
  end

  // main sequence
  initial begin
    nrst   = 1'b0;
    wb_req = '0;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    #1;
    check("trig_out", trig_out, TRIG_RST);
    check("run_n_out", run_n_out, 1'b1);
    check("infuse", infuse, INFUSE_RST);
    $display("test reset done");
    foreach (rows[i]) begin
      wb(1'b1, ADDR_CTRL, 32'(rows[i].mode), rd);
      pins.drive(rows[i].ch, rows[i].lvl, F + 12);
      check("infuse", infuse, rows[i].inf);
      check("run_n_out", run_n_out, rows[i].run_n);
      check("evt_pulses", 32'(evt_seen), 32'(rows[i].evt));
      $display("test row %0d done", i);
    end
    // short trigger glitch must be dropped
    pins.drive(CH_TRIG, 1'b0, F / 2);
    pins.drive(CH_TRIG, 1'b1, F + 12);
    check("evt_glitch", 32'(evt_seen), 32'h1);
    wb(1'b0, ADDR_EVT, 32'h0, rd);
    check("evt_reg", rd, 32'h1);
    $display("test glitch done");
    // software run set beats clear, then clear alone
    wb(1'b1, ADDR_CTRL, 32'h60, rd);
    wb(1'b0, ADDR_STAT, 32'h0, rd);
    check("stat_run", rd[STAT_RUN_BIT], 1'b1);
    check("run_n_out", run_n_out, 1'b0);
    check("stat_inf", rd[STAT_INF_BIT], 1'b1);
    check("stat_pins", rd[STAT_PIN_LSB +: N_CH], 32'h7);
    wb(1'b1, ADDR_CTRL, 32'h40, rd);
    wb(1'b0, ADDR_STAT, 32'h0, rd);
    check("run_n_out", run_n_out, 1'b1);
    // trigger output under software control
    wb(1'b1, ADDR_CTRL, 32'h10, rd);
    wb(1'b0, ADDR_STAT, 32'h0, rd);
    check("trig_out", trig_out, 1'b1);
    check("stat_trig", rd[STAT_TRIG_BIT], 1'b1);
    wb(1'b1, ADDR_CTRL, 32'h00, rd);
    wb(1'b0, ADDR_STAT, 32'h0, rd);
    check("trig_out", trig_out, 1'b0);
    // mode value 3 is not a mode and leaves the setting alone
    wb(1'b1, ADDR_CTRL, 32'h01, rd);
    wb(1'b1, ADDR_CTRL, 32'h03, rd);
    wb(1'b0, ADDR_CTRL, 32'h0, rd);
    check("ctrl_mode", rd[1:0], 2'h1);
    $display("test software done");
    // chain size limits
    foreach (chain[i]) begin
      wb(1'b1, ADDR_CHAIN, chain[i][0], rd);
      wb(1'b0, ADDR_CHAIN, 32'h0, rd);
      check("chain", rd, chain[i][1]);
      wb(1'b0, ADDR_STAT, 32'h0, rd);
      check("chain_refused", rd[STAT_REFUSED], chain[i][2][0]);
    end
    wb(1'b0, 8'h10, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    $display("test chain done");
    // mid-run reset with direction and footswitch held low
    pins.drive(CH_DIR, 1'b0, F + 12);
    check("infuse", infuse, 1'b0);
    wb(1'b1, ADDR_CTRL, 32'h32, rd);
    check("trig_out", trig_out, 1'b1);
    check("run_n_out", run_n_out, 1'b0);
    pins.drive(CH_FOOT, 1'b0, 2);
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    #1;
    check("trig_out", trig_out, TRIG_RST);
    check("run_n_out", run_n_out, 1'b1);
    check("infuse", infuse, INFUSE_RST);
    wb(1'b0, ADDR_CTRL, 32'h0, rd);
    check("ctrl_rst", rd, 32'h0);
    wb(1'b0, ADDR_CHAIN, 32'h0, rd);
    check("chain_rst", rd, 32'(CHAIN_CNT_RST));
    // low pins are seen as falling edges once settled
    repeat (F + 12) @(posedge sys_clk);
    check("infuse", infuse, 1'b0);
    check("run_n_out", run_n_out, 1'b0);
    pins.drive(CH_FOOT, 1'b1, F + 12);
    check("run_n_out", run_n_out, 1'b0);
    check("evt_pulses", 32'(evt_seen), 32'h1);
    $display("test mid reset done");
    stop_test();
  end
endmodule : test_pump_user_io_control
